// >>> pkg/sdram_core_pkg.sv
// shared constants for the sdram burst access core
// assumes one clock domain; all pins are synchronous to clk

package sdram_core_pkg;

	// ----------------------------------------
	// array geometry
	// ----------------------------------------
	localparam int BANKS = 4;
	localparam int BANK_W = 2;
	localparam int ROWS = 8192;
	localparam int ROW_W = 13;
	localparam int COLS_X4 = 2048;
	localparam int COLS_X8 = 1024;
	localparam int COLS_X16 = 512;
	localparam int COL_W_X16 = 9;
	localparam int DQ_W_X16 = 16;
	localparam int AP_BIT = 10;

	// ----------------------------------------
	// command codes {ras_n, cas_n, we_n}
	// ----------------------------------------
	localparam logic [2:0] CMD_ACT = 3'h3;
	localparam logic [2:0] CMD_RD = 3'h5;
	localparam logic [2:0] CMD_WR = 3'h4;
	localparam logic [2:0] CMD_PRE = 3'h2;
	localparam logic [2:0] CMD_BST = 3'h6;

	// ----------------------------------------
	// burst length codes
	// ----------------------------------------
	localparam logic [2:0] BL_1 = 3'h0;
	localparam logic [2:0] BL_2 = 3'h1;
	localparam logic [2:0] BL_4 = 3'h2;
	localparam logic [2:0] BL_8 = 3'h3;
	localparam logic [2:0] BL_PAGE = 3'h7;

	// ----------------------------------------
	// self-timed precharge
	// ----------------------------------------
	localparam int CLK_NS = 100;
	localparam int T_RP_NS = 20;
	localparam int T_RP_RAW = (T_RP_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_RP_CYC = (T_RP_RAW < 1) ? 1 : T_RP_RAW;
	localparam int PRE_W = 4;

	// ----------------------------------------
	// register port
	// ----------------------------------------
	localparam logic [3:0] REG_CFG = 4'h0;
	localparam logic [3:0] REG_STAT = 4'h1;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam int CFG_BL_LSB = 0;
	localparam int CFG_IL_BIT = 3;

	typedef enum logic [1:0] {
		B_IDLE = 2'b00,
		B_READ = 2'b01,
		B_WRITE = 2'b10
	} burst_state_t;

endpackage : sdram_core_pkg

// >>> rtl/sdram_burst_access_core.sv
// burst access core of a four-bank synchronous dram
// assumes a controller on the same clock keeps row open/close order and refresh duty

// Behaviour
// - every pin but the asynchronous reset nrst is taken only on the rising clock edge, and the controller sets them up to it.
// - each of four banks has 8192 rows, with 2048, 1024 or 512 columns by data width.
// - activate takes the bank inputs as bank number and the thirteen address bits as row.
// - read or write takes its address as the first column of the burst in the open row.
// - later columns of the burst are made inside, for the set length and order.
// - bursts are one, two, four, eight locations or a whole row, for reads and writes.
// - burst terminate ends a running burst early, and is the way to stop a page burst.
// - access with auto precharge closes the row by itself once the burst is done.
// - a new column may be taken every cycle, so back-to-back accesses are random.
// - one bank may be precharged while another is being accessed.
// - address bit ten on read or write asks for auto precharge and is no column bit.
// - with device select high all commands are ignored, running bursts and masking go on.
module sdram_burst_access_core
	import sdram_core_pkg::*;
#(
	parameter int DQ_W = DQ_W_X16,
	parameter int COL_W = COL_W_X16,
	parameter int MEM_AW = 8
) (
	input wire logic clk, // system clock
	input wire logic nrst, // async reset, active low
	input wire logic cs_n, // device select, active low
	input wire logic ras_n, // row strobe, active low
	input wire logic cas_n, // column strobe, active low
	input wire logic we_n, // write enable, active low
	input wire logic [BANK_W-1:0] ba, // bank select
	input wire logic [ROW_W-1:0] addr, // row / column address
	input wire logic dqm, // data mask
	input wire logic [DQ_W-1:0] dq_in, // data pin, input side
	output logic [DQ_W-1:0] dq_out, // data pin, output side
	output logic dq_oe, // data pin driven
	output logic dq_valid, // read word on dq_out
	input wire logic dq_ready, // receiver takes read word
	input wire logic [3:0] reg_addr, // register address
	input wire logic [7:0] reg_wdata, // register write data
	input wire logic reg_wr, // register write strobe
	input wire logic reg_rd, // register read strobe
	output logic [7:0] reg_rdata // read data, one cycle later
);

	// ----------------------------------------
	// pin sampling
	// ----------------------------------------
	logic cs_n_q;
	logic [2:0] cmd_q;
	logic [BANK_W-1:0] ba_q;
	logic [ROW_W-1:0] addr_q;
	logic dqm_q;
	logic [DQ_W-1:0] dq_q;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cs_n_q <= 1'b1;
			cmd_q <= 3'h7;
			ba_q <= '0;
			addr_q <= '0;
			dqm_q <= 1'b1;
			dq_q <= '0;
		end else begin
			cs_n_q <= cs_n;
			cmd_q <= {ras_n, cas_n, we_n};
			ba_q <= ba;
			addr_q <= addr;
			dqm_q <= dqm;
			dq_q <= dq_in;
		end
	end

	// ----------------------------------------
	// register port
	// ----------------------------------------
	logic [7:0] cfg_q;
	logic [7:0] stat;
	logic [2:0] bl_code;
	logic il_mode;

	assign bl_code = cfg_q[CFG_BL_LSB +: 3];
	assign il_mode = cfg_q[CFG_IL_BIT];

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cfg_q <= CFG_RST;
		end else if (reg_wr && reg_addr == REG_CFG) begin
			cfg_q <= reg_wdata;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				REG_CFG: reg_rdata <= cfg_q;
				REG_STAT: reg_rdata <= stat;
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	logic is_act;
	logic is_rd;
	logic is_wr;
	logic is_pre;
	logic is_bst;
	logic acc_go;
	logic [10:0] col_raw;
	logic [COL_W-1:0] col_in;
	logic [BANKS-1:0] open_q;
	logic [BANKS-1:0] bank_busy;
	logic [ROW_W-1:0] row_q [BANKS];

	// a high select masks the decoder only; bursts keep running
	assign is_act = !cs_n_q && cmd_q == CMD_ACT;
	assign is_rd = !cs_n_q && cmd_q == CMD_RD;
	assign is_wr = !cs_n_q && cmd_q == CMD_WR;
	assign is_pre = !cs_n_q && cmd_q == CMD_PRE;
	assign is_bst = !cs_n_q && cmd_q == CMD_BST;
	// an access to a closed bank is dropped rather than guessed at
	assign acc_go = (is_rd || is_wr) && open_q[ba_q];
	// bit ten is skipped; bit eleven is a column bit only on the widest array
	assign col_raw = {addr_q[11], addr_q[9:0]};
	assign col_in = col_raw[COL_W-1:0];

	// ----------------------------------------
	// burst engine
	// ----------------------------------------
	burst_state_t st_q;
	logic [BANK_W-1:0] bank_q;
	logic [COL_W-1:0] base_q;
	logic [COL_W-1:0] cnt_q;
	logic [COL_W:0] len_q;
	logic page_q;
	logic il_q;
	logic ap_q;
	logic [COL_W-1:0] mask;
	logic [COL_W-1:0] col_cur;
	logic step;
	logic last;
	logic ends_now;
	logic pre_hit;
	logic ap_fire;
	logic buf_ready;

	function automatic logic [COL_W:0] bl_len(input logic [2:0] code);
		case (code)
			BL_2: return (COL_W + 1)'(2);
			BL_4: return (COL_W + 1)'(4);
			BL_8: return (COL_W + 1)'(8);
			BL_PAGE: return (COL_W + 1)'(1 << COL_W);
			default: return (COL_W + 1)'(1);
		endcase
	endfunction : bl_len

	assign mask = COL_W'(len_q - 1'b1);

	always_comb begin
		if (page_q) begin
			col_cur = COL_W'(base_q + cnt_q); // wraps inside the row
		end else if (il_q) begin
			col_cur = base_q ^ cnt_q;
		end else begin
			col_cur = (base_q & ~mask) | (COL_W'(base_q + cnt_q) & mask);
		end
	end

	// reads stall on a full buffer so no word is lost
	assign step = (st_q == B_WRITE) || (st_q == B_READ && buf_ready);
	assign last = ((COL_W + 1)'({1'b0, cnt_q} + 1'b1) == len_q);
	assign ends_now = step && last && !page_q;
	assign pre_hit = is_pre && (addr_q[AP_BIT] || ba_q == bank_q);
	assign ap_fire = ap_q && st_q != B_IDLE && (ends_now || is_bst || acc_go || pre_hit);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_q <= B_IDLE;
			bank_q <= '0;
			base_q <= '0;
			cnt_q <= '0;
			len_q <= (COL_W + 1)'(1);
			page_q <= 1'b0;
			il_q <= 1'b0;
			ap_q <= 1'b0;
		end else if (acc_go) begin
			// a new access cuts any running burst short
			st_q <= is_rd ? B_READ : B_WRITE;
			bank_q <= ba_q;
			base_q <= col_in;
			cnt_q <= '0;
			len_q <= bl_len(bl_code);
			page_q <= (bl_code == BL_PAGE);
			il_q <= il_mode;
			ap_q <= addr_q[AP_BIT];
		end else if (is_bst || ends_now || (pre_hit && st_q != B_IDLE)) begin
			st_q <= B_IDLE;
			ap_q <= 1'b0;
		end else if (st_q != B_IDLE && step) begin
			cnt_q <= COL_W'(cnt_q + 1'b1);
		end
	end

	// ----------------------------------------
	// bank state
	// ----------------------------------------
	genvar b;
	generate
		for (b = 0; b < BANKS; b++) begin : g_bank
			logic [PRE_W-1:0] pre_q;
			logic pre_go;

			// each bank times its own precharge, so others stay usable
			assign pre_go = (is_pre && (addr_q[AP_BIT] || ba_q == b)) || (ap_fire && bank_q == b);
			assign bank_busy[b] = (pre_q != '0);

			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					open_q[b] <= 1'b0;
					row_q[b] <= '0;
					pre_q <= '0;
				end else if (pre_go) begin
					open_q[b] <= 1'b0;
					pre_q <= PRE_W'(T_RP_CYC);
				end else if (bank_busy[b]) begin
					pre_q <= PRE_W'(pre_q - 1'b1);
				end else if (is_act && ba_q == b) begin
					open_q[b] <= 1'b1;
					row_q[b] <= addr_q;
				end
			end
		end
	endgenerate

	assign stat = {2'h0, |bank_busy, st_q != B_IDLE, open_q};

	// ----------------------------------------
	// storage and data path
	// ----------------------------------------
	// only MEM_AW low bits of {bank,row,col} are stored; full depth would not fit flops
	localparam int FULL_W = BANK_W + ROW_W + COL_W;
	logic [FULL_W-1:0] loc;
	logic [MEM_AW-1:0] idx;
	logic [DQ_W-1:0] mem_q [2**MEM_AW];
	logic [DQ_W-1:0] wdat_q;
	logic wmask_q;
	logic buf_valid;

	assign loc = {bank_q, row_q[bank_q], col_cur};
	assign idx = loc[MEM_AW-1:0];

	// data taken with a write command lines up with the burst's first cycle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wdat_q <= '0;
			wmask_q <= 1'b1;
		end else begin
			wdat_q <= dq_q;
			wmask_q <= dqm_q;
		end
	end

	always_ff @(posedge clk) begin
		if (st_q == B_WRITE && !wmask_q) begin
			mem_q[idx] <= wdat_q;
		end
	end

	sdram_skid_buf #(
		.W(DQ_W)
	) u_rd_buf (
		.clk(clk),
		.nrst(nrst),
		.in_valid(st_q == B_READ),
		.in_ready(buf_ready),
		.in_data(mem_q[idx]),
		.out_valid(buf_valid),
		.out_ready(dq_ready),
		.out_data(dq_out)
	);

	assign dq_valid = buf_valid;
	assign dq_oe = buf_valid && !dqm_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_cs_ignore;
		@(posedge clk) disable iff (!nrst)
		(cs_n_q && st_q == B_IDLE) |=> (open_q == $past(open_q));
	endproperty
	a_cs_ignore: assert property (p_cs_ignore) else $error("command taken while deselected");

	property p_act_open;
		@(posedge clk) disable iff (!nrst)
		(is_act && !bank_busy[ba_q] && !is_pre) |=>
			(open_q[$past(ba_q)] && row_q[$past(ba_q)] == $past(addr_q));
	endproperty
	a_act_open: assert property (p_act_open) else $error("activate did not open row");

	property p_start_col;
		@(posedge clk) disable iff (!nrst)
		acc_go |=> (st_q != B_IDLE && col_cur == $past(col_in) && bank_q == $past(ba_q));
	endproperty
	a_start_col: assert property (p_start_col) else $error("burst start column wrong");

	property p_seq_step;
		@(posedge clk) disable iff (!nrst)
		(st_q == B_WRITE && !acc_go && !is_bst && !pre_hit && !ends_now) |=>
			(cnt_q == COL_W'($past(cnt_q) + 1'b1));
	endproperty
	a_seq_step: assert property (p_seq_step) else $error("burst counter did not advance");

	property p_len4;
		@(posedge clk) disable iff (!nrst)
		(acc_go && is_wr && bl_code == BL_4) ##1 (!acc_go && !is_bst && !is_pre) [*4]
			|=> (st_q == B_IDLE);
	endproperty
	a_len4: assert property (p_len4) else $error("four-beat write length wrong");

	property p_bst;
		@(posedge clk) disable iff (!nrst)
		is_bst |=> (st_q == B_IDLE) ##1 (st_q == B_IDLE || $past(acc_go));
	endproperty
	a_bst: assert property (p_bst) else $error("terminate did not stop burst");

	property p_ap;
		@(posedge clk) disable iff (!nrst)
		ap_fire |=> (bank_busy[$past(bank_q)] && !open_q[$past(bank_q)]);
	endproperty
	a_ap: assert property (p_ap) else $error("auto precharge not started");

	property p_ap_flag;
		@(posedge clk) disable iff (!nrst)
		acc_go |=> (ap_q == $past(addr_q[AP_BIT]));
	endproperty
	a_ap_flag: assert property (p_ap_flag) else $error("bit ten not taken as precharge");

	property p_rnd;
		@(posedge clk) disable iff (!nrst)
		(acc_go && st_q != B_IDLE) |=> (base_q == $past(col_in) && cnt_q == '0);
	endproperty
	a_rnd: assert property (p_rnd) else $error("back-to-back access not taken");

	property p_interleave;
		@(posedge clk) disable iff (!nrst)
		(is_pre && !addr_q[AP_BIT] && ba_q != bank_q && st_q != B_IDLE && !ends_now && !ap_q)
			|=> (st_q == $past(st_q));
	endproperty
	a_interleave: assert property (p_interleave) else $error("precharge disturbed other bank");

endmodule : sdram_burst_access_core

// >>> rtl/sdram_skid_buf.sv
// two-entry buffer with valid/ready on both sides
// assumes the producer holds data while in_valid and not in_ready

module sdram_skid_buf #(
	parameter int W = 16
) (
	input wire logic clk, // system clock
	input wire logic nrst, // async reset, active low
	input wire logic in_valid, // producer has a word
	output logic in_ready, // buffer can take a word
	input wire logic [W-1:0] in_data, // word from producer
	output logic out_valid, // buffer holds a word
	input wire logic out_ready, // consumer takes the word
	output logic [W-1:0] out_data // oldest word
);

	logic [W-1:0] ent_q [2];
	logic wp_q;
	logic rp_q;
	logic [1:0] cnt_q;
	logic push;
	logic pop;

	assign in_ready = (cnt_q != 2'h2);
	assign out_valid = (cnt_q != 2'h0);
	assign out_data = ent_q[rp_q];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			ent_q[wp_q] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wp_q <= 1'b0;
			rp_q <= 1'b0;
			cnt_q <= 2'h0;
		end else begin
			if (push) begin
				wp_q <= ~wp_q;
			end
			if (pop) begin
				rp_q <= ~rp_q;
			end
			cnt_q <= 2'(cnt_q + {1'b0, push} - {1'b0, pop});
		end
	end

endmodule : sdram_skid_buf

// >>> tb/sdram_burst_access_core_test.sv
// self-checking bench for the burst access core
// assumes the default x16 geometry and storage that aliases on the low column bits
module sdram_burst_access_core_test
	import sdram_core_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, nrst, cs_n, ras_n, cas_n, we_n, dqm, dq_oe, dq_valid, dq_ready, reg_wr, reg_rd;
	logic [1:0] ba;
	logic [12:0] addr;
	logic [15:0] dq_in, dq_out;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, v;
	logic [15:0] rq[$];
	int errors = 0;
	int cmp_count = 0;
	int i;
	sdram_burst_access_core dut (.clk(clk), .nrst(nrst), .cs_n(cs_n), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dqm(dqm), .dq_in(dq_in),
		.dq_out(dq_out), .dq_oe(dq_oe), .dq_valid(dq_valid), .dq_ready(dq_ready),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata));
	sdram_ctrl_model ctl (.clk(clk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
		.ba(ba), .addr(addr), .dqm(dqm), .dq_in(dq_in), .dq_ready(dq_ready),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata));
	initial clk = 1'b0;
	always #50 clk = ~clk;
	always @(posedge clk) if (dq_valid === 1'b1 && dq_ready === 1'b1) rq.push_back(dq_out);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task final_report;
		$display("checks %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : final_report
	task chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task got(input int n);
		int k;
		for (k = 0; k < 60 && rq.size() < n; k++) @(posedge clk);
		chk(16'(rq.size()), 16'(n));
	endtask : got
	task cfg(input logic [2:0] code, input logic il);
		ctl.reg_w(REG_CFG, {4'h0, il, code});
	endtask : cfg
	task stat(input logic [3:0] e);
		ctl.reg_r(REG_STAT, v);
		chk({12'h000, v[3:0]}, {12'h000, e});
	endtask : stat
	// data of each column is its own number, so order faults show directly
	task wr(input logic [8:0] c, input int n);
		int k;
		ctl.cmd(1'b0, CMD_WR, 2'h1, {4'h0, c}, 16'ha000 | 16'(c));
		for (k = 1; k < n; k++) ctl.cmd(1'b0, 3'h7, 2'h0, 13'h0000, 16'ha000 | 16'(c + 9'(k)));
		ctl.nop(2);
	endtask : wr
	task rdchk(input logic [8:0] c, input int bl, input logic il);
		logic [8:0] col;
		int k;
		rq.delete();
		ctl.cmd(1'b0, CMD_RD, 2'h1, {4'h0, c}, 16'h0000);
		ctl.nop(1);
		got(bl);
		for (k = 0; k < bl; k++) begin
			col = il ? (c ^ 9'(k)) : ((c & ~9'(bl - 1)) | ((c + 9'(k)) & 9'(bl - 1)));
			chk(rq[k], 16'ha000 | 16'(col));
		end
	endtask : rdchk
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_reset;
		ctl.reg_r(REG_CFG, v);
		chk({8'h00, v}, 16'h0000);
		ctl.reg_r(REG_STAT, v);
		chk({8'h00, v}, 16'h0000);
		ctl.reg_r(4'h9, v);
		chk({8'h00, v}, 16'h0000);
		chk({15'h0000, dq_valid}, 16'h0000);
		$display("reset test done");
	endtask : t_reset
	task t_seq;
		cfg(BL_4, 1'b0);
		ctl.cmd(1'b0, CMD_ACT, 2'h1, 13'h1abc, 16'h0000);
		ctl.nop(2);
		stat(4'h2);
		wr(9'h008, 4);
		rdchk(9'h00a, 4, 1'b0);
		cfg(BL_4, 1'b1);
		rdchk(9'h009, 4, 1'b1);
		cfg(BL_2, 1'b0);
		rdchk(9'h00b, 2, 1'b0);
		cfg(BL_1, 1'b0);
		rq.delete();
		ctl.cmd(1'b0, CMD_RD, 2'h1, 13'h000b, 16'h0000);
		ctl.cmd(1'b0, CMD_RD, 2'h1, 13'h0008, 16'h0000);
		ctl.cmd(1'b0, CMD_RD, 2'h1, 13'h000a, 16'h0000);
		ctl.nop(1);
		got(3);
		chk(rq[0], 16'ha00b);
		chk(rq[1], 16'ha008);
		chk(rq[2], 16'ha00a);
		$display("burst order test done");
	endtask : t_seq
	task t_stall;
		cfg(BL_8, 1'b0);
		wr(9'h010, 8);
		ctl.rdy(1'b0);
		rq.delete();
		ctl.cmd(1'b0, CMD_RD, 2'h1, 13'h0010, 16'h0000);
		ctl.nop(8);
		chk({15'h0000, dq_valid}, 16'h0001);
		chk(16'(rq.size()), 16'h0000);
		ctl.rdy(1'b1);
		got(8);
		for (i = 0; i < 8; i++) chk(rq[i], 16'ha010 + 16'(i));
		$display("stall test done");
	endtask : t_stall
	task t_cs;
		cfg(BL_4, 1'b0);
		rq.delete();
		ctl.cmd(1'b0, CMD_RD, 2'h1, 13'h0008, 16'h0000);
		ctl.cmd(1'b1, CMD_WR, 2'h1, 13'h0008, 16'h5555);
		ctl.nop(1);
		got(4);
		for (i = 0; i < 4; i++) chk(rq[i], 16'ha008 + 16'(i));
		ctl.cmd(1'b1, CMD_ACT, 2'h3, 13'h0555, 16'h0000);
		ctl.nop(2);
		stat(4'h2);
		$display("deselect test done");
	endtask : t_cs
	// a masked write must not land, and a high mask blanks the output enable
	task t_mask;
		cfg(BL_1, 1'b0);
		wr(9'h020, 1);
		ctl.msk(1'b1);
		ctl.cmd(1'b0, CMD_WR, 2'h1, 13'h0020, 16'h5a5a);
		ctl.nop(2);
		ctl.msk(1'b0);
		ctl.rdy(1'b0);
		rq.delete();
		ctl.cmd(1'b0, CMD_RD, 2'h1, 13'h0020, 16'h0000);
		ctl.nop(4);
		chk({15'h0000, dq_oe}, 16'h0001);
		ctl.msk(1'b1);
		ctl.nop(2);
		chk({15'h0000, dq_oe}, 16'h0000);
		ctl.msk(1'b0);
		ctl.rdy(1'b1);
		got(1);
		chk(rq[0], 16'ha020);
		$display("mask test done");
	endtask : t_mask
	task t_page;
		cfg(BL_PAGE, 1'b0);
		rq.delete();
		ctl.cmd(1'b0, CMD_RD, 2'h1, 13'h0008, 16'h0000);
		ctl.nop(2);
		ctl.cmd(1'b0, CMD_BST, 2'h0, 13'h0000, 16'h0000);
		ctl.nop(8);
		chk(rq[0], 16'ha008);
		chk(rq[1], 16'ha009);
		chk(16'(rq.size()), 16'h0003);
		chk(rq[2], 16'ha00a);
		ctl.reg_r(REG_STAT, v);
		chk({15'h0000, v[4]}, 16'h0000);
		$display("page burst test done");
	endtask : t_page
	task t_ap;
		cfg(BL_1, 1'b0);
		ctl.cmd(1'b0, CMD_ACT, 2'h2, 13'h0123, 16'h0000);
		ctl.nop(1);
		rq.delete();
		ctl.cmd(1'b0, CMD_RD, 2'h1, 13'h0408, 16'h0000);
		ctl.nop(1);
		got(1);
		chk(rq[0], 16'ha008);
		ctl.nop(2);
		stat(4'h4);
		cfg(BL_2, 1'b0);
		ctl.cmd(1'b0, CMD_ACT, 2'h1, 13'h1abc, 16'h0000);
		ctl.nop(1);
		rq.delete();
		// precharge of bank two lands in the middle of the bank one burst
		ctl.cmd(1'b0, CMD_RD, 2'h1, 13'h0009, 16'h0000);
		ctl.cmd(1'b0, CMD_PRE, 2'h2, 13'h0000, 16'h0000);
		ctl.nop(1);
		got(2);
		chk(rq[0], 16'ha009);
		chk(rq[1], 16'ha008);
		ctl.nop(3);
		stat(4'h2);
		$display("auto precharge test done");
	endtask : t_ap
	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		nrst = 1'b0;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_seq();
		t_stall();
		t_cs();
		t_mask();
		t_page();
		t_ap();
		final_report();
	end
	// the whole run needs well under a thousand cycles
	initial begin
		repeat (4000) @(posedge clk);
		errors++;
		$display("watchdog expired");
		final_report();
	end
endmodule : sdram_burst_access_core_test

// >>> tb/sdram_ctrl_model.sv
// controller-side model: command pins, write data, read ready and register port
// assumes the core samples every pin on the rising edge of clk
module sdram_ctrl_model
	import sdram_core_pkg::*;
(
	input wire logic clk, // system clock
	output logic cs_n, // device select, active low
	output logic ras_n, // row strobe, active low
	output logic cas_n, // column strobe, active low
	output logic we_n, // write enable, active low
	output logic [BANK_W-1:0] ba, // bank select
	output logic [ROW_W-1:0] addr, // row / column address
	output logic dqm, // data mask
	output logic [DQ_W_X16-1:0] dq_in, // write data
	output logic dq_ready, // read word taken
	output logic [3:0] reg_addr, // register address
	output logic [7:0] reg_wdata, // register write data
	output logic reg_wr, // register write strobe
	output logic reg_rd, // register read strobe
	input wire logic [7:0] reg_rdata // register read data
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{cs_n, ras_n, cas_n, we_n} = 4'hf;
		ba = 2'h0;
		addr = 13'h0000;
		dqm = 1'b0;
		dq_in = 16'h0000;
		dq_ready = 1'b1;
		{reg_addr, reg_wdata, reg_wr, reg_rd} = 14'h0000;
	end
	// ----------------------------------------
	// command pins
	// ----------------------------------------
	// pins change only just after the edge so each edge sees them settled
	// sequences open a row before access and close a bank before a new row
	// no self refresh code is ever sent; runs stay far inside the refresh window
	task cmd(input logic s, input logic [2:0] c, input logic [1:0] b, input logic [12:0] a,
		input logic [15:0] d);
		@(posedge clk);
		cs_n <= s;
		{ras_n, cas_n, we_n} <= c;
		ba <= b;
		addr <= a;
		dq_in <= d;
	endtask : cmd
	// idle data flips every cycle so stale write data never looks meaningful
	task nop(input int n);
		repeat (n) cmd(1'b0, 3'h7, 2'h0, 13'h0000, ~dq_in);
	endtask : nop
	task rdy(input logic r);
		@(posedge clk);
		dq_ready <= r;
	endtask : rdy
	// call only after a nop: the command pins hold their value for this cycle
	task msk(input logic m);
		@(posedge clk);
		dqm <= m;
	endtask : msk
	// ----------------------------------------
	// register port
	// ----------------------------------------
	task reg_w(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : reg_w
	task reg_r(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		v = reg_rdata;
	endtask : reg_r
endmodule : sdram_ctrl_model
